// ==== hw/rec_ctl_pkg.sv ====
// Purpose: shared constants for the record-entry control logic
// Assumes: 100 MHz aclk
// Notes:   time figures kept in their own units, cycle counts derived
package rec_ctl_pkg;
    localparam int          CLK_NS          = 10;
    localparam int          DEBOUNCE_MS     = 5;
    localparam int          DEBOUNCE_CYC    = DEBOUNCE_MS * 1000000 / CLK_NS;
    localparam int          BLINK_MS        = 250;
    localparam int          BLINK_CYC       = BLINK_MS * 1000000 / CLK_NS;
    localparam int          MIC_PAD_DB      = 20;
    localparam int          NUM_TRACKS      = 2;
    localparam int          NUM_BUTTONS     = 7;
    // button vector positions
    localparam int          BTN_PLAY        = 0;
    localparam int          BTN_RECORD      = 1;
    localparam int          BTN_PAUSE       = 2;
    localparam int          BTN_STOP        = 3;
    localparam int          BTN_PEDAL       = 4;
    localparam int          BTN_ARM0        = 5;
    localparam int          BTN_ARM1        = 6;
    // register map
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;
    localparam int          CTRL_SRC_MIC    = 0;
    localparam int          CTRL_PAD        = 1;
    localparam int          CTRL_MON_LO     = 2;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0004;
    localparam logic [1:0]  MON_INPUT       = 2'h0;
    localparam logic [1:0]  MON_SYNC        = 2'h1;
    localparam logic [1:0]  MON_PLAYBACK    = 2'h2;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    typedef enum logic [2:0] {ST_STOP, ST_PLAY, ST_RECORD, ST_PRELOAD, ST_REC_PAUSE} trans_state_t;
endpackage

// ==== hw/rec_ctl.sv ====
// Purpose: record-entry, pedal punch and monitor routing control of a two-track deck
// Assumes: buttons are synchronous, high while pressed; registers over AXI4-Lite
// Notes:   status register shows transport state, armed and recording tracks
`timescale 1ns/1ps

module rec_ctl_press #(
    parameter int CYC = 2
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic raw,
    output logic      press
);
    logic [$clog2(CYC+1)-1:0] cnt;
    logic                     stable;
    logic                     prev;
    wire                      differ = (raw != stable);
    wire                      settle = differ && (cnt == ($clog2(CYC+1))'(CYC - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt    <= '0;
            stable <= 1'b0;
            prev   <= 1'b0;
            press  <= 1'b0;
        end else begin
            cnt    <= (differ && !settle) ? cnt + 1'b1 : '0;
            if (settle)
                stable <= raw;
            prev   <= stable;
            press  <= stable && !prev;
        end
    end
endmodule

module rec_ctl
    import rec_ctl_pkg::*;
#(
    parameter int DEB_CYC   = DEBOUNCE_CYC,
    parameter int BLINK_LEN = BLINK_CYC
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // front panel and pedal
    input  wire logic [NUM_BUTTONS-1:0] buttons,
    // transport and switching
    output logic                       motor_run,
    output logic [NUM_TRACKS-1:0]      rec_enable,
    output logic [NUM_TRACKS-1:0]      mon_source,
    output logic                       mon_playback_head,
    output logic                       mon_input_direct,
    output logic                       sel_mic,
    output logic                       mic_pad,
    output logic                       record_lamp,
    output logic                       pause_lamp,
    // axi4-lite slave
    input  wire logic [7:0]            s_awaddr,
    input  wire logic                  s_awvalid,
    output logic                       s_awready,
    input  wire logic [31:0]           s_wdata,
    input  wire logic [3:0]            s_wstrb,
    input  wire logic                  s_wvalid,
    output logic                       s_wready,
    output logic [1:0]                 s_bresp,
    output logic                       s_bvalid,
    input  wire logic                  s_bready,
    input  wire logic [7:0]            s_araddr,
    input  wire logic                  s_arvalid,
    output logic                       s_arready,
    output logic [31:0]                s_rdata,
    output logic [1:0]                 s_rresp,
    output logic                       s_rvalid,
    input  wire logic                  s_rready
);
    logic [NUM_BUTTONS-1:0] press;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BUTTONS; gi++) begin : g_deb
            rec_ctl_press #(.CYC(DEB_CYC)) u_press (
                .aclk    (aclk),
                .aresetn (aresetn),
                .raw     (buttons[gi]),
                .press   (press[gi])
            );
        end
    endgenerate

    // armed state toggles per press, like latching buttons
    logic [NUM_TRACKS-1:0]  armed;
    logic [31:0]            ctrl;
    trans_state_t           state;
    trans_state_t           next_state;
    logic                   punched;
    logic                   next_punched;
    logic [$clog2(BLINK_LEN+1)-1:0] blink_cnt;
    logic                   blink;

    wire                    any_armed  = |armed;
    wire                    p_play     = press[BTN_PLAY];
    wire                    p_rec      = press[BTN_RECORD];
    wire                    p_pause    = press[BTN_PAUSE];
    wire                    p_stop     = press[BTN_STOP];
    wire                    p_pedal    = press[BTN_PEDAL];
    wire                    play_rec   = p_play && p_rec;
    wire [1:0]              mon_sel    = ctrl[CTRL_MON_LO +: 2];
    wire                    in_sync    = (mon_sel == MON_SYNC);
    wire [NUM_TRACKS-1:0]   arm_press  = press[BTN_ARM0 +: NUM_TRACKS];
    wire [NUM_TRACKS-1:0]   next_armed = armed ^ arm_press;
    wire                    next_recording = (next_state == ST_RECORD) ||
                                             (next_state == ST_PRELOAD) ||
                                             (next_state == ST_PLAY && next_punched);

    // transport: pedal never appears in motion terms
    always_comb begin
        next_state   = state;
        next_punched = punched;
        case (state)
            ST_STOP: begin
                if (play_rec)
                    next_state = any_armed ? ST_RECORD : ST_PRELOAD;
                else if (p_play)
                    next_state = ST_PLAY;
            end
            ST_PLAY: begin
                if (play_rec)
                    next_state = any_armed ? ST_RECORD : ST_PRELOAD;
                else if (p_stop || p_pause)
                    next_state = ST_STOP;
                else if (p_pedal && in_sync)
                    next_punched = !punched;
            end
            ST_RECORD, ST_PRELOAD: begin
                if (p_pause)
                    next_state = ST_REC_PAUSE;
                else if (p_stop)
                    next_state = ST_STOP;
            end
            ST_REC_PAUSE: begin
                if (p_play)
                    next_state = ST_RECORD;
                else if (p_stop)
                    next_state = ST_STOP;
            end
            default: next_state = ST_STOP;
        endcase
        if (next_state != ST_PLAY)
            next_punched = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state   <= ST_STOP;
            punched <= 1'b0;
            armed   <= '0;
        end else begin
            state   <= next_state;
            punched <= next_punched;
            armed   <= next_armed;
        end
    end

    // record lamp blink
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt <= '0;
            blink     <= 1'b0;
        end else if (blink_cnt == ($clog2(BLINK_LEN+1))'(BLINK_LEN - 1)) begin
            blink_cnt <= '0;
            blink     <= !blink;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    wire in_rec_mode = (state == ST_RECORD) || (state == ST_PRELOAD) || (state == ST_REC_PAUSE);

    // outputs all registered; recording tracks follow arming immediately
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            motor_run         <= 1'b0;
            rec_enable        <= '0;
            mon_source        <= '0;
            mon_playback_head <= 1'b0;
            mon_input_direct  <= 1'b0;
            sel_mic           <= 1'b0;
            mic_pad           <= 1'b0;
            record_lamp       <= 1'b0;
            pause_lamp        <= 1'b0;
        end else begin
            motor_run         <= (next_state == ST_PLAY) || (next_state == ST_RECORD) ||
                                 (next_state == ST_PRELOAD);
            rec_enable        <= next_recording ? next_armed : '0;
            mon_source        <= in_sync ? next_armed : '0;
            mon_playback_head <= (mon_sel == MON_PLAYBACK);
            mon_input_direct  <= (mon_sel == MON_INPUT);
            sel_mic           <= ctrl[CTRL_SRC_MIC];
            mic_pad           <= ctrl[CTRL_SRC_MIC] && ctrl[CTRL_PAD];
            record_lamp       <= in_rec_mode && (any_armed || blink);
            pause_lamp        <= (state == ST_REC_PAUSE);
        end
    end

    // axi4-lite: address and data taken together, one response each
    wire wr_go    = s_awvalid && s_wvalid && !s_bvalid;
    wire wr_ctrl  = (s_awaddr == ADDR_CTRL);
    wire rd_go    = s_arvalid && !s_rvalid;
    wire [31:0] status_word = {14'h0, rec_enable, 6'h0, armed, 5'h0, state};
    wire [31:0] rd_word     = (s_araddr == ADDR_CTRL)   ? ctrl :
                              (s_araddr == ADDR_STATUS) ? status_word : 32'h0;
    wire rd_ok    = (s_araddr == ADDR_CTRL) || (s_araddr == ADDR_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl      <= CTRL_RESET;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0;
            s_rresp   <= RESP_OKAY;
        end else begin
            s_awready <= wr_go && !s_awready;
            s_wready  <= wr_go && !s_awready;
            if (wr_go && !s_awready) begin
                if (wr_ctrl && s_wstrb[0])
                    ctrl <= {28'h0, s_wdata[3:0]};
                s_bresp  <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
                s_bvalid <= 1'b1;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
            s_arready <= rd_go && !s_arready;
            if (rd_go && !s_arready) begin
                s_rdata  <= rd_word;
                s_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                s_rvalid <= 1'b1;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // checks; pedal alone means no transport button in the same cycle
    sequence s_pedal_alone;
        p_pedal && !p_play && !p_rec && !p_stop && !p_pause;
    endsequence

    property p_pedal_no_motion;
        @(posedge aclk) disable iff (!aresetn)
        s_pedal_alone |=> $stable(motor_run);
    endproperty
    a_pedal_no_motion: assert property (p_pedal_no_motion)
        else $error("pedal changed motion");

    property p_rec_alone;
        @(posedge aclk) disable iff (!aresetn)
        p_rec && $onehot(press) |=> $stable(state);
    endproperty
    a_rec_alone: assert property (p_rec_alone)
        else $error("record alone changed state");

    property p_resume;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_REC_PAUSE && p_play |=> state == ST_RECORD;
    endproperty
    a_resume: assert property (p_resume)
        else $error("play did not resume recording");

    property p_pause_stop;
        @(posedge aclk) disable iff (!aresetn)
        (state == ST_RECORD || state == ST_PRELOAD) && p_pause |=> !motor_run && rec_enable == '0;
    endproperty
    a_pause_stop: assert property (p_pause_stop)
        else $error("pause did not halt");

    property p_start;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_STOP && play_rec && any_armed && arm_press == '0 |=> rec_enable == armed && motor_run;
    endproperty
    a_start: assert property (p_start)
        else $error("record start failed");

    property p_punch;
        @(posedge aclk) disable iff (!aresetn)
        s_pedal_alone ##0 (state == ST_PLAY && in_sync && arm_press == '0)
        |=> rec_enable == ($past(punched) ? '0 : armed);
    endproperty
    a_punch: assert property (p_punch)
        else $error("pedal did not toggle punch");
endmodule

// ==== dv/panel_model.sv ====
// Purpose: front panel and punch pedal model
// Assumes: buttons are high while pressed
// Notes:   each press outlasts the debounce span, then fully releases
`timescale 1ns/1ps

module panel_model
    import rec_ctl_pkg::*;
(
    // clock
    input  wire logic                   aclk,
    // button levels
    output logic [NUM_BUTTONS-1:0]      buttons
);
    initial buttons = '0;

    // buttons in the mask go down on one edge, so they count as together
    task automatic press(input logic [NUM_BUTTONS-1:0] m);
        @(posedge aclk);
        buttons <= m;
        repeat (8) @(posedge aclk);
        buttons <= '0;
        repeat (8) @(posedge aclk);
    endtask
endmodule

// ==== dv/testbench.sv ====
// Purpose: self-checking bench for the record-entry control
// Assumes: short debounce and blink counts
// Notes:   expectations follow the transport rules, not the design
`timescale 1ns/1ps

module testbench
    import rec_ctl_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [NUM_BUTTONS-1:0] buttons;
    logic motor_run, mon_playback_head, mon_input_direct, sel_mic, mic_pad, record_lamp, pause_lamp;
    logic [1:0] rec_enable, mon_source, s_bresp, s_rresp;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    int err_count = 0, checked = 0;
    logic [31:0] d;
    logic [1:0] r;

    always #5 aclk = ~aclk;

    panel_model panel (.aclk(aclk), .buttons(buttons));
    rec_ctl #(.DEB_CYC(2), .BLINK_LEN(4)) i_rec_ctl (.aclk(aclk), .aresetn(aresetn), .buttons(buttons),
        .motor_run(motor_run), .rec_enable(rec_enable), .mon_source(mon_source),
        .mon_playback_head(mon_playback_head), .mon_input_direct(mon_input_direct), .sel_mic(sel_mic),
        .mic_pad(mic_pad), .record_lamp(record_lamp), .pause_lamp(pause_lamp),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    // address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] sb, output logic [1:0] rs);
        @(posedge aclk);
        s_awaddr <= a;
        s_awvalid <= 1;
        s_wdata <= v;
        s_wstrb <= sb;
        s_wvalid <= 1;
        s_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 0;
            if (s_wready) s_wvalid <= 0;
        end while (!s_bvalid);
        rs = s_bresp;
        s_bready <= 0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 0;
        end while (!s_rvalid);
        v = s_rdata;
        rs = s_rresp;
        s_rready <= 0;
    endtask

    task automatic st(input logic [2:0] s, input logic [1:0] a, input logic [1:0] re, input logic m);
        rd(ADDR_STATUS, d, r);
        chk("state", s, d[2:0]);
        chk("armed", a, d[9:8]);
        chk("rec_field", re, d[17:16]);
        chk("rec_enable", re, rec_enable);
        chk("motor_run", m, motor_run);
    endtask

    task automatic t_preload();
        int n = 0;
        panel.press(7'h02);
        st(3'h0, 2'h0, 2'h0, 0);
        panel.press(7'h03);
        st(3'h3, 2'h0, 2'h0, 1);
        // blink half period is 4 cycles, so any 16 cycles hold 8 lit
        repeat (16) begin
            @(posedge aclk);
            n += int'(record_lamp);
        end
        chk("record_lamp_blink", 8, n);
        panel.press(7'h20);
        chk("rec_enable", 2'h1, rec_enable);
        chk("mon_source", 2'h1, mon_source);
        panel.press(7'h04);
        st(3'h4, 2'h1, 2'h0, 0);
        chk("pause_lamp", 1, pause_lamp);
        chk("record_lamp", 1, record_lamp);
        panel.press(7'h01);
        st(3'h2, 2'h1, 2'h1, 1);
        chk("pause_lamp", 0, pause_lamp);
        chk("record_lamp", 1, record_lamp);
        panel.press(7'h08);
        st(3'h0, 2'h1, 2'h0, 0);
        chk("record_lamp", 0, record_lamp);
        $display("test preload done");
    endtask

    task automatic t_record();
        panel.press(7'h40);
        panel.press(7'h03);
        st(3'h2, 2'h3, 2'h3, 1);
        panel.press(7'h04);
        st(3'h4, 2'h3, 2'h0, 0);
        panel.press(7'h08);
        panel.press(7'h20);
        st(3'h0, 2'h2, 2'h0, 0);
        chk("pause_lamp", 0, pause_lamp);
        $display("test record done");
    endtask

    task automatic t_pedal();
        panel.press(7'h10);
        st(3'h0, 2'h2, 2'h0, 0);
        panel.press(7'h01);
        panel.press(7'h10);
        st(3'h1, 2'h2, 2'h2, 1);
        panel.press(7'h10);
        st(3'h1, 2'h2, 2'h0, 1);
        panel.press(7'h03);
        st(3'h2, 2'h2, 2'h2, 1);
        panel.press(7'h08);
        panel.press(7'h01);
        panel.press(7'h04);
        st(3'h0, 2'h2, 2'h0, 0);
        $display("test pedal done");
    endtask

    task automatic t_regs();
        rd(ADDR_CTRL, d, r);
        chk("ctrl_reset", CTRL_RESET, d);
        wr(ADDR_CTRL, 32'h3, 4'hf, r);
        chk("bresp", RESP_OKAY, r);
        chk("sel_mic", 1, sel_mic);
        chk("mic_pad", 1, mic_pad);
        chk("mon_input_direct", 1, mon_input_direct);
        chk("mon_playback_head", 0, mon_playback_head);
        chk("mon_source", 2'h0, mon_source);
        wr(ADDR_CTRL, 32'ha, 4'hf, r);
        chk("sel_mic", 0, sel_mic);
        chk("mic_pad", 0, mic_pad);
        chk("mon_playback_head", 1, mon_playback_head);
        chk("mon_input_direct", 0, mon_input_direct);
        wr(ADDR_CTRL, 32'h4, 4'hf, r);
        chk("mon_source", 2'h2, mon_source);
        wr(ADDR_CTRL, 32'h1, 4'h0, r);
        rd(ADDR_CTRL, d, r);
        chk("ctrl_no_strobe", 32'h4, d);
        wr(8'h10, 32'h1, 4'hf, r);
        chk("bresp", RESP_SLVERR, r);
        rd(8'h10, d, r);
        chk("rresp", RESP_SLVERR, r);
        chk("rdata", 32'h0, d);
        $display("test regs done");
    endtask

    task automatic t_reset();
        wr(ADDR_CTRL, 32'h3, 4'hf, r);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADDR_CTRL, d, r);
        chk("ctrl_reset", CTRL_RESET, d);
        st(3'h0, 2'h0, 2'h0, 0);
        $display("test reset done");
    endtask

    task automatic conclude();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100us;
        err_count++;
        conclude();
    end

    initial begin
        {s_awaddr, s_araddr, s_wdata, s_wstrb} <= '0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("motor_run", 0, motor_run);
        t_preload();
        t_record();
        t_pedal();
        t_regs();
        t_reset();
        conclude();
    end
endmodule
